//--- adc_seq_pkg.sv
// Constants, register map and state codes for the conversion sequencer.
package adc_seq_pkg;
	localparam logic [11:0] ctrl_offset = 12'h000;
	localparam logic [11:0] delay_offset = 12'h004;
	localparam logic [11:0] ptr_offset = 12'h008;
	localparam logic [11:0] result_offset = 12'h00c;
	localparam logic [11:0] status_offset = 12'h010;
	localparam logic [11:0] core_data_offset = 12'h014;
	// Control register field positions.
	localparam int start_pos = 0;
	localparam int single_pos = 1;
	localparam int cal_pos = 2;
	localparam int inter_pos = 3;
	localparam int map_pos = 4;
	localparam int buf_pos = 5;
	localparam int core_reset_pos = 6;
	localparam int mask_pos = 7;
	// Pointer register field positions.
	localparam int ptr1_pos = 0;
	localparam int ptr2_pos = 4;
	localparam int inc1_pos = 8;
	localparam int inc2_pos = 9;
	// Result register field positions.
	localparam int res1_pos = 0;
	localparam int res2_pos = 16;
	localparam logic [7:0] delay_reset = 8'h00;
	localparam logic mask_reset = 1'b1;
	localparam int result_width = 10;
	localparam int num_slots = 8;
	// Logic clock and tick timing.
	localparam longint clk_hz = 200000000;
	localparam longint tick_hz = 32768;
	localparam logic [12:0] tick_div = 13'(clk_hz / tick_hz);
	localparam real sync_delay_us = 2.0;
	localparam logic [9:0] sync_cycles = 10'($rtoi(sync_delay_us * 200.0 + 0.999));
	localparam logic [7:0] conv_cycles = 8'h20;
	localparam logic [1:0] resp_okay = 2'b00;
	localparam logic [1:0] resp_slverr = 2'b10;
	typedef enum logic [5:0] {
		st_idle = 6'b000001,
		st_sync = 6'b000010,
		st_delay = 6'b000100,
		st_conv = 6'b001000,
		st_gap = 6'b010000,
		st_done = 6'b100000
	} seq_state_e;
endpackage

//--- adc_conversion_sequencer.sv
// Conversion sequencer with AXI4-Lite register slave.
`timescale 1ns/1ps
module adc_conversion_sequencer (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic clk_en,
	input wire logic external_trigger_pin,
	input wire logic [adc_seq_pkg::result_width-1:0] core_result,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic pll_enable,
	output logic [2:0] channel_select,
	output logic input_map_select,
	output logic input_buffer_enable,
	output logic core_sample,
	output logic core_calibrate,
	output logic core_reset,
	output logic conversion_done_irq
);
	import adc_seq_pkg::*;

	// ==========================================================
	// Register state
	seq_state_e state_q, state_d;
	logic software_start_bit_q, single_channel_select_q, calibration_request_q;
	logic inter_conversion_delay_enable_q, input_map_select_q, buffer_bit_q;
	logic conversion_done_mask_q, conversion_done_flag_q, core_reset_q;
	logic [7:0] start_delay_ticks_q;
	logic [2:0] first_slot_pointer_q, second_slot_pointer_q;
	logic first_pointer_autoinc_q, second_pointer_autoinc_q;
	logic [result_width-1:0] slot_q [num_slots];
	logic slots_valid_q;
	logic [1:0] queue_q;
	logic trig_meta_q, trig_sync_q, trig_prev_q;
	logic series_cal_q;
	logic [12:0] tick_cnt_q;
	logic [9:0] wait_cnt_q;
	logic [7:0] ticks_left_q;
	logic [2:0] conv_idx_q;
	logic [7:0] conv_cnt_q;
	logic pll_q, chan_buf_q, sample_q, cal_out_q, irq_q;
	logic [2:0] chan_q;
	logic aw_held_q, w_held_q, awready_q, wready_q;
	logic [11:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic bvalid_q, arready_q, rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] bresp_q, rresp_q;

	// ==========================================================
	// Decode
	wire tick = (tick_cnt_q == tick_div - 13'd1);
	wire trig_edge = trig_sync_q & ~trig_prev_q;
	wire wr_fire = aw_held_q & w_held_q & ~bvalid_q;
	wire wr_ctrl = wr_fire & (aw_addr_q == ctrl_offset) & w_strb_q[0];
	wire wr_delay = wr_fire & (aw_addr_q == delay_offset) & w_strb_q[0];
	wire wr_ptr0 = wr_fire & (aw_addr_q == ptr_offset) & w_strb_q[0];
	wire wr_ptr1 = wr_fire & (aw_addr_q == ptr_offset) & w_strb_q[1];
	wire wr_status = wr_fire & (aw_addr_q == status_offset) & w_strb_q[0];
	wire wr_known = (aw_addr_q == ctrl_offset) | (aw_addr_q == delay_offset) | (aw_addr_q == ptr_offset)
		| (aw_addr_q == result_offset) | (aw_addr_q == status_offset) | (aw_addr_q == core_data_offset);
	wire rd_fire = s_axi_arvalid & arready_q;
	wire rd_result = rd_fire & (s_axi_araddr == result_offset);
	wire sw_start = wr_ctrl & w_data_q[start_pos] & ~software_start_bit_q;
	wire req_in = sw_start | trig_edge;
	wire busy = ~state_q[0];
	wire series_end = (state_q == st_done);
	// A delay always starts on a fresh tick, so a programmed delay is a whole number of ticks.
	wire delay_entry = (state_d == st_delay) & (state_q != st_delay);
	wire launch = (state_q == st_idle) & (queue_q != 2'd0);
	wire conv_end = (state_q == st_conv) & (conv_cnt_q == conv_cycles - 8'd1);
	wire last_conv = (conv_idx_q == 3'd7);
	// Looking one index ahead keeps the channel steady from the first cycle of a back-to-back conversion.
	wire [2:0] conv_idx_d = conv_end ? conv_idx_q + 3'd1 : conv_idx_q;
	// Single-channel mode uses the first pointer; multi-channel walks the index.
	wire [2:0] next_chan = single_channel_select_q ? first_slot_pointer_q : conv_idx_d;
	wire [2:0] rd_slot1 = first_slot_pointer_q;
	wire [2:0] rd_slot2 = second_slot_pointer_q;
	wire [31:0] result_word = slots_valid_q ?
		({6'd0, slot_q[rd_slot2], 6'd0, slot_q[rd_slot1]}) : 32'h0;
	wire [31:0] ctrl_word = {24'd0, conversion_done_mask_q, 1'b0, buffer_bit_q, input_map_select_q,
		inter_conversion_delay_enable_q, calibration_request_q, single_channel_select_q, software_start_bit_q};
	wire [31:0] ptr_word = {22'd0, second_pointer_autoinc_q, first_pointer_autoinc_q,
		1'b0, second_slot_pointer_q, 1'b0, first_slot_pointer_q};
	wire [31:0] status_word = {24'd0, 2'd0, queue_q, 1'b0, slots_valid_q, busy, conversion_done_flag_q};
	wire rd_known = (s_axi_araddr == ctrl_offset) | (s_axi_araddr == delay_offset)
		| (s_axi_araddr == ptr_offset) | (s_axi_araddr == result_offset) | (s_axi_araddr == status_offset);
	wire [31:0] rd_word = (s_axi_araddr == ctrl_offset) ? ctrl_word :
		(s_axi_araddr == delay_offset) ? {24'd0, start_delay_ticks_q} :
		(s_axi_araddr == ptr_offset) ? ptr_word :
		(s_axi_araddr == result_offset) ? result_word :
		(s_axi_araddr == status_offset) ? status_word : 32'h0;

	// ==========================================================
	// Sequencer state machine
	always_comb begin
		state_d = state_q;
		case (state_q)
			st_idle: if (launch) state_d = st_sync;
			st_sync: if (wait_cnt_q == 10'd0) state_d = st_delay;
			st_delay: if (tick && ticks_left_q == 8'd0) state_d = st_conv;
			st_conv: if (conv_end) state_d = last_conv ? st_done : (inter_conversion_delay_enable_q ? st_delay : st_conv);
			st_gap: state_d = st_conv;
			st_done: state_d = st_idle;
			default: state_d = st_idle;
		endcase
		if (core_reset_q) state_d = st_idle;
	end

	// ==========================================================
	// Sequencer datapath
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			state_q <= st_idle;
			tick_cnt_q <= 13'd0;
			wait_cnt_q <= 10'd0;
			ticks_left_q <= 8'd0;
			conv_idx_q <= 3'd0;
			conv_cnt_q <= 8'd0;
			queue_q <= 2'd0;
			series_cal_q <= 1'b0;
			trig_meta_q <= 1'b0;
			trig_sync_q <= 1'b0;
			trig_prev_q <= 1'b0;
			slots_valid_q <= 1'b0;
			for (int i = 0; i < num_slots; i++) slot_q[i] <= '0;
		end else if (clk_en) begin
			state_q <= state_d;
			trig_meta_q <= external_trigger_pin;
			trig_sync_q <= trig_meta_q;
			trig_prev_q <= trig_sync_q;
			// The tick counter runs on ref_clk, so its rate never follows the PLL setting.
			tick_cnt_q <= (tick | delay_entry) ? 13'd0 : tick_cnt_q + 13'd1;
			// A third request is dropped rather than overwriting a queued one.
			if (core_reset_q) queue_q <= 2'd0;
			else if (req_in && !launch && queue_q != 2'd2) queue_q <= queue_q + 2'd1;
			else if (launch && !req_in) queue_q <= queue_q - 2'd1;
			if (launch) begin
				wait_cnt_q <= sync_cycles;
				ticks_left_q <= start_delay_ticks_q;
				conv_idx_q <= 3'd0;
				series_cal_q <= calibration_request_q;
			end
			if (state_q == st_sync && wait_cnt_q != 10'd0) wait_cnt_q <= wait_cnt_q - 10'd1;
			if (state_q == st_delay && tick && ticks_left_q != 8'd0) ticks_left_q <= ticks_left_q - 8'd1;
			// Clearing outside a conversion keeps an aborted conversion from shortening the next one.
			conv_cnt_q <= (state_q == st_conv && !conv_end) ? conv_cnt_q + 8'd1 : 8'd0;
			if (conv_end) begin
				if (!series_cal_q) slot_q[conv_idx_q] <= core_result;
				conv_idx_q <= conv_idx_q + 3'd1;
				ticks_left_q <= start_delay_ticks_q;
			end
			if (series_end) slots_valid_q <= ~series_cal_q;
		end
	end

	// ==========================================================
	// Host-visible control registers
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			software_start_bit_q <= 1'b0;
			single_channel_select_q <= 1'b0;
			calibration_request_q <= 1'b0;
			inter_conversion_delay_enable_q <= 1'b0;
			input_map_select_q <= 1'b0;
			buffer_bit_q <= 1'b0;
			conversion_done_mask_q <= mask_reset;
			conversion_done_flag_q <= 1'b0;
			core_reset_q <= 1'b0;
			start_delay_ticks_q <= delay_reset;
		end else if (clk_en) begin
			core_reset_q <= wr_ctrl & w_data_q[core_reset_pos];
			if (wr_ctrl) begin
				single_channel_select_q <= w_data_q[single_pos];
				inter_conversion_delay_enable_q <= w_data_q[inter_pos];
				input_map_select_q <= w_data_q[map_pos];
				buffer_bit_q <= w_data_q[buf_pos];
				conversion_done_mask_q <= w_data_q[mask_pos];
			end
			if (wr_ctrl && w_data_q[cal_pos]) calibration_request_q <= 1'b1;
			else if (series_end && series_cal_q) calibration_request_q <= 1'b0;
			if (req_in) software_start_bit_q <= 1'b1;
			else if (series_end && queue_q == 2'd0) software_start_bit_q <= 1'b0;
			else if (core_reset_q) software_start_bit_q <= 1'b0;
			if (series_end) conversion_done_flag_q <= 1'b1;
			else if (wr_status && w_data_q[0]) conversion_done_flag_q <= 1'b0;
			if (wr_delay) start_delay_ticks_q <= w_data_q[7:0];
		end
	end

	// ==========================================================
	// Readout pointers
	slot_pointer_reg u_slot_pointer_reg_first (
		.ref_clk,
		.resetn,
		.clk_en,
		.load_ptr(wr_ptr0),
		.load_inc(wr_ptr1),
		.ptr_in(w_data_q[ptr1_pos +: 3]),
		.inc_in(w_data_q[inc1_pos]),
		.result_read(rd_result),
		.ptr(first_slot_pointer_q),
		.inc(first_pointer_autoinc_q)
	);

	slot_pointer_reg u_slot_pointer_reg_second (
		.ref_clk,
		.resetn,
		.clk_en,
		.load_ptr(wr_ptr0),
		.load_inc(wr_ptr1),
		.ptr_in(w_data_q[ptr2_pos +: 3]),
		.inc_in(w_data_q[inc2_pos]),
		.result_read(rd_result),
		.ptr(second_slot_pointer_q),
		.inc(second_pointer_autoinc_q)
	);

	// ==========================================================
	// Core-facing outputs, all registered
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			pll_q <= 1'b0;
			chan_q <= 3'd0;
			chan_buf_q <= 1'b0;
			sample_q <= 1'b0;
			cal_out_q <= 1'b0;
			irq_q <= 1'b0;
		end else if (clk_en) begin
			pll_q <= busy | (queue_q != 2'd0);
			chan_q <= next_chan;
			chan_buf_q <= buffer_bit_q & (state_d == st_conv);
			sample_q <= (state_d == st_conv) & ((state_q != st_conv) | conv_end);
			cal_out_q <= series_cal_q & busy;
			irq_q <= conversion_done_flag_q & ~conversion_done_mask_q;
		end
	end

	// ==========================================================
	// AXI4-Lite slave
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			aw_held_q <= 1'b0;
			w_held_q <= 1'b0;
			awready_q <= 1'b1;
			wready_q <= 1'b1;
			aw_addr_q <= 12'h0;
			w_data_q <= 32'h0;
			w_strb_q <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q <= resp_okay;
			arready_q <= 1'b0;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0;
			rresp_q <= resp_okay;
		end else if (clk_en) begin
			if (s_axi_awvalid && !aw_held_q) begin
				aw_held_q <= 1'b1;
				awready_q <= 1'b0;
				aw_addr_q <= {s_axi_awaddr[11:2], 2'b00};
			end
			if (s_axi_wvalid && !w_held_q) begin
				w_held_q <= 1'b1;
				wready_q <= 1'b0;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (wr_fire) begin
				bvalid_q <= 1'b1;
				bresp_q <= wr_known ? resp_okay : resp_slverr;
			end else if (bvalid_q && s_axi_bready) begin
				bvalid_q <= 1'b0;
				aw_held_q <= 1'b0;
				w_held_q <= 1'b0;
				awready_q <= 1'b1;
				wready_q <= 1'b1;
			end
			arready_q <= s_axi_arvalid & ~arready_q & ~rvalid_q;
			if (rd_fire) begin
				rvalid_q <= 1'b1;
				rdata_q <= rd_word;
				rresp_q <= rd_known ? resp_okay : resp_slverr;
			end else if (rvalid_q && s_axi_rready) rvalid_q <= 1'b0;
		end
	end

	assign s_axi_awready = awready_q;
	assign s_axi_wready = wready_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
	assign pll_enable = pll_q;
	assign channel_select = chan_q;
	assign input_map_select = input_map_select_q;
	assign input_buffer_enable = chan_buf_q;
	assign core_sample = sample_q;
	assign core_calibrate = cal_out_q;
	assign core_reset = core_reset_q;
	assign conversion_done_irq = irq_q;
endmodule

// ==========================================================
// One readout pointer with its auto-increment enable
module slot_pointer_reg (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic clk_en,
	input wire logic load_ptr,
	input wire logic load_inc,
	input wire logic [2:0] ptr_in,
	input wire logic inc_in,
	input wire logic result_read,
	output logic [2:0] ptr,
	output logic inc
);
	logic [2:0] ptr_q;
	logic inc_q;

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			ptr_q <= 3'd0;
			inc_q <= 1'b0;
		end else if (clk_en) begin
			// A pointer write wins over an increment that falls in the same cycle.
			if (load_ptr) ptr_q <= ptr_in;
			else if (result_read && inc_q) ptr_q <= ptr_q + 3'd1;
			if (load_inc) inc_q <= inc_in;
		end
	end

	assign ptr = ptr_q;
	assign inc = inc_q;
endmodule

//--- adc_core_model.sv
// Behavioural converter core that answers each conversion with a channel-coded value.
`timescale 1ns/1ps
module adc_core_model (
	input wire logic ref_clk,
	input wire logic core_sample,
	input wire logic [2:0] channel_select,
	output logic [9:0] core_result
);
	logic [5:0] cnt_q = 6'h00;
	always @(posedge ref_clk) begin
		if (core_sample) begin
			cnt_q <= 6'h28;
		end else if (cnt_q != 6'h00) begin
			cnt_q <= cnt_q - 6'h01;
		end
	end
	// Outside a conversion the inverse code is shown, so a late sample reads as a wrong value.
	assign core_result = (cnt_q != 6'h00) ? {channel_select, 7'h2a} : ~{channel_select, 7'h2a};
endmodule

//--- adc_conversion_sequencer_asserts.sv
// Concurrent checks on the conversion sequencer ports.
`timescale 1ns/1ps
module adc_conversion_sequencer_asserts (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic external_trigger_pin,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic pll_enable,
	input wire logic [2:0] channel_select,
	input wire logic input_buffer_enable,
	input wire logic core_sample,
	input wire logic core_calibrate,
	input wire logic conversion_done_irq
);
	// ====
	// Assertions.
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	AST_TRIG_PLL: assert property (
		$rose(external_trigger_pin) && !pll_enable ##1 external_trigger_pin [*3] |-> ##[0:4] pll_enable)
		else $error("trigger edge did not start the pll");
	AST_SAMPLE_PLL: assert property (core_sample |-> pll_enable) else $error("conversion without pll");
	AST_BUF_ACTIVE: assert property (input_buffer_enable |-> pll_enable) else $error("buffer on while idle");
	AST_SAMPLE_GAP: assert property (core_sample |=> !core_sample [*8]) else $error("conversion cut short");
	AST_CH_STABLE: assert property (
		core_sample |=> $stable(channel_select) [*8]) else $error("channel moved during conversion");
	AST_AR_ANSWER: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
	AST_R_DONE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("rvalid stuck");
	AST_B_DONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid stuck");
	// ====
	// Coverage.
	C_SAMPLE: cover property (core_sample);
	C_CAL: cover property (core_calibrate);
	C_IRQ: cover property (conversion_done_irq);
	C_BUF: cover property (input_buffer_enable);
endmodule
bind adc_conversion_sequencer adc_conversion_sequencer_asserts u_adc_conversion_sequencer_asserts (.ref_clk, .resetn,
	.external_trigger_pin, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_bvalid, .s_axi_bready,
	.pll_enable, .channel_select, .input_buffer_enable, .core_sample, .core_calibrate, .conversion_done_irq);

//--- adc_conversion_sequencer_test.sv
// Self-checking bench for the conversion sequencer.
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_mismatch++; \
	$display("wrong value at %0t: got %h expected %h", $time, a, e); end end
module adc_conversion_sequencer_test;
	import adc_seq_pkg::*;
	logic ref_clk = 1'b0, resetn = 1'b0, clk_en = 1'b1, external_trigger_pin = 1'b0;
	logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
	logic [31:0] s_axi_wdata = 32'h0, rd_val;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [1:0] rd_resp;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, pll_enable, input_map_select;
	wire logic input_buffer_enable, core_sample, core_calibrate, core_reset, conversion_done_irq;
	wire logic [1:0] s_axi_bresp, s_axi_rresp;
	wire logic [31:0] s_axi_rdata;
	wire logic [2:0] channel_select;
	wire logic [9:0] core_result;
	int n_mismatch = 0, checked = 0, n_samp = 0, n_rst = 0, base;
	adc_conversion_sequencer u_adc_conversion_sequencer (.ref_clk, .resetn, .clk_en, .external_trigger_pin,
		.core_result, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pll_enable, .channel_select, .input_map_select,
		.input_buffer_enable, .core_sample, .core_calibrate, .core_reset, .conversion_done_irq);
	adc_core_model u_adc_core_model (.ref_clk, .core_sample, .channel_select, .core_result);
	initial forever #2.5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		if (core_sample) n_samp++;
		if (core_reset) n_rst++;
	end
	// ====
	// Bus and helper tasks.
	task wrap_up;
		$display("comparisons %0d, mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge ref_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid && n < 64);
		s_axi_bready <= 1'b0;
		if (n >= 64) begin n_mismatch++; wrap_up(); end
	endtask
	task automatic rd(input logic [11:0] a);
		int n;
		n = 0;
		@(posedge ref_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid && n < 64);
		rd_val = s_axi_rdata;
		rd_resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
		if (n >= 64) begin n_mismatch++; wrap_up(); end
	endtask
	task automatic rchk(input logic [11:0] a, input logic [31:0] e);
		rd(a);
		`CHK(rd_val, e)
	endtask
	task automatic wait_idle;
		int n;
		n = 0;
		do begin rd(status_offset); n++; end while ((rd_val[1] !== 1'b0 || rd_val[5:4] !== 2'b00) && n < 8000);
		if (n >= 8000) begin n_mismatch++; wrap_up(); end
	endtask
	task automatic pulse;
		@(posedge ref_clk);
		external_trigger_pin <= 1'b1;
		repeat (4) @(posedge ref_clk);
		external_trigger_pin <= 1'b0;
	endtask
	function automatic logic [31:0] pair(input logic [2:0] a, input logic [2:0] b);
		return {6'h00, b, 7'h2a, 6'h00, a, 7'h2a};
	endfunction
	// ====
	// Scenarios.
	task t_reset;
		rchk(ctrl_offset, 32'h80);
		rchk(delay_offset, 32'h0);
		rd(core_data_offset);
		`CHK(rd_resp, resp_slverr)
	endtask
	task t_cal;
		wr(ctrl_offset, 32'h05);
		repeat (500) @(posedge ref_clk);
		`CHK(core_calibrate, 1'b1)
		`CHK(pll_enable, 1'b1)
		wait_idle();
		`CHK(core_calibrate, 1'b0)
		rchk(ctrl_offset, 32'h0);
		rchk(status_offset, 32'h1);
		`CHK(conversion_done_irq, 1'b1)
		rchk(result_offset, 32'h0);
		wr(status_offset, 32'h1);
		repeat (3) @(posedge ref_clk);
		`CHK(conversion_done_irq, 1'b0)
	endtask
	task t_multi;
		wr(ptr_offset, 32'h363);
		wr(ctrl_offset, 32'h01);
		base = n_samp;
		repeat (6400) @(posedge ref_clk);
		`CHK(n_samp, base)
		wait_idle();
		`CHK(n_samp, base + 8)
		rchk(status_offset, 32'h5);
		rchk(result_offset, pair(3'h3, 3'h6));
		rchk(result_offset, pair(3'h4, 3'h7));
		rchk(ptr_offset, 32'h305);
	endtask
	task t_single;
		wr(ptr_offset, 32'h05);
		wr(ctrl_offset, 32'h32);
		`CHK(input_map_select, 1'b1)
		base = n_samp;
		pulse();
		repeat (20) @(posedge ref_clk);
		pulse();
		rchk(ctrl_offset, 32'h33);
		wait_idle();
		`CHK(n_samp, base + 16)
		rchk(ctrl_offset, 32'h32);
		rchk(result_offset, pair(3'h5, 3'h5));
	endtask
	task t_inter;
		wr(ctrl_offset, 32'h3b);
		base = n_samp;
		repeat (6600) @(posedge ref_clk);
		`CHK(n_samp, base + 1)
		`CHK(input_buffer_enable, 1'b0)
		`CHK(pll_enable, 1'b1)
		clk_en <= 1'b0;
		repeat (200) @(posedge ref_clk);
		clk_en <= 1'b1;
		repeat (5900) @(posedge ref_clk);
		`CHK(n_samp, base + 1)
	endtask
	task t_core_reset;
		wr(ctrl_offset, 32'h72);
		rchk(ctrl_offset, 32'h32);
		`CHK(n_rst, 1)
		rchk(result_offset, pair(3'h5, 3'h5));
		rchk(status_offset, 32'h5);
		wr(ctrl_offset, 32'h32);
		repeat (300) @(posedge ref_clk);
		`CHK(n_samp, base + 1)
	endtask
	initial begin
		repeat (8) @(posedge ref_clk);
		resetn <= 1'b1;
		t_reset();
		t_cal();
		t_multi();
		t_single();
		t_inter();
		t_core_reset();
		wrap_up();
	end
endmodule
